/* shared/twoc_defs.vh */
/*
 * Offsets, field positions, reset values and mode codes for the timer
 * waveform output control block.
 * Assumes inclusion by bare name from plain Verilog-2005 design files.
 */
`ifndef TWOC_DEFS_VH
`define TWOC_DEFS_VH

// ==========================================================
// Register byte offsets on APB
`define TWOC_OFS_CTRL_A     8'h00
`define TWOC_OFS_CTRL_B     8'h04
`define TWOC_OFS_CMP_A      8'h08
`define TWOC_OFS_CMP_B      8'h0C
`define TWOC_OFS_COUNT      8'h10
`define TWOC_OFS_STATUS     8'h14

// ==========================================================
// Field positions
`define TWOC_CA_ACT_HI      7
`define TWOC_CA_ACT_LO      6
`define TWOC_CB_ACT_HI      5
`define TWOC_CB_ACT_LO      4
`define TWOC_WGM_LOW_HI     1
`define TWOC_WGM_LOW_LO     0
`define TWOC_WGM_HIGH_BIT   3
`define TWOC_RUN_BIT        0
`define TWOC_CTRL_A_MASK    8'hF3
`define TWOC_CTRL_B_MASK    8'h09

// ==========================================================
// Reset values and counts
`define TWOC_RST_BYTE       8'h00
`define TWOC_MAX            8'hFF
`define TWOC_BOTTOM         8'h00

// ==========================================================
// Waveform modes
`define TWOC_M_NORMAL       3'h0
`define TWOC_M_PC_FF        3'h1
`define TWOC_M_CTC          3'h2
`define TWOC_M_FAST_FF      3'h3
`define TWOC_M_RSV4         3'h4
`define TWOC_M_PC_CA        3'h5
`define TWOC_M_RSV6         3'h6
`define TWOC_M_FAST_CA      3'h7

`endif

/* hdl/twoc_out_chan.v */
/*
 * One compare output channel: decodes the compare action code against
 * the waveform class and drives the output latch.
 * Assumes match, bottom and top strobes from the counter on pclk.
 */
`timescale 1ns/1ns
module twoc_out_chan #(
    parameter IS_A = 1
) (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Configuration
    input  wire [1:0] action,
    input  wire       mode_hi,
    input  wire       non_pwm,
    input  wire       fast,
    input  wire       phase,
    // Counter events
    input  wire       match,
    input  wire       cmp_is_top,
    input  wire       at_bottom,
    input  wire       at_top,
    input  wire       counting_up,
    // Output
    output reg        level_r,
    output reg        drive_r
);

    reg level_nxt;
    reg drive_nxt;
    reg special;

    // ==========================================================
    // Output level decode
    always @* begin
        level_nxt = level_r;
        drive_nxt = 1'b0;
        special   = action[1] & cmp_is_top;
        if (non_pwm) begin
            drive_nxt = |action;
            if (match && action == 2'b01)
                level_nxt = ~level_r;
            else if (match && action[1])
                level_nxt = action[0];
        end else if (action == 2'b01) begin
            drive_nxt = (IS_A != 0) && mode_hi;
            if (drive_nxt && match)
                level_nxt = ~level_r;
        end else if (action[1]) begin
            drive_nxt = 1'b1;
            if (fast) begin
                if (at_bottom)
                    level_nxt = ~action[0];
                else if (match && !special)
                    level_nxt = action[0];
            end else if (phase) begin
                if (special && at_top)
                    level_nxt = ~action[0];
                else if (match && !special)
                    level_nxt = counting_up ? action[0] : ~action[0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= 1'b0;
            drive_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
            drive_r <= drive_nxt;
        end
    end

endmodule // twoc_out_chan

/* hdl/twoc_timer.v */
/*
 * Timer waveform output control: APB register file, 8-bit counter with
 * four waveform classes, and two compare output channels.
 * Assumes an APB master on pclk and port logic outside that mixes the
 * output override with the pin's direction bit.
 */
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "twoc_defs.vh"
module twoc_timer (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Compare outputs
    output wire        compare_out_a_pin,
    output wire        compare_out_a_override,
    output wire        compare_out_b_pin,
    output wire        compare_out_b_override,
    // Counter status
    output reg         overflow_flag
);

    reg  [7:0] timer_control_a_r;
    reg  [3:0] timer_control_b_r;
    reg  [7:0] cmp_a_buf_r;
    reg  [7:0] cmp_b_buf_r;
    reg  [7:0] compare_value_a_r;
    reg  [7:0] compare_value_b_r;
    reg  [7:0] count_r;
    reg  [7:0] count_nxt;
    reg        down_r;
    reg        down_nxt;
    reg        ovf_nxt;
    reg  [7:0] top;
    reg        load_now;
    reg  [31:0] rdata_nxt;
    reg        err_nxt;

    wire       run;
    wire       wr_cnt;
    wire [2:0] waveform_mode_select;
    wire       non_pwm;
    wire       fast;
    wire       phase;
    wire       at_top;
    wire       at_bottom;
    wire       acc;

    // ==========================================================
    // Mode decode
    // Three-bit mode
    assign waveform_mode_select = {
        timer_control_b_r[`TWOC_WGM_HIGH_BIT],
        timer_control_a_r[`TWOC_WGM_LOW_HI:`TWOC_WGM_LOW_LO]};
    assign run     = timer_control_b_r[`TWOC_RUN_BIT];
    assign non_pwm = (waveform_mode_select == `TWOC_M_NORMAL) ||
                     (waveform_mode_select == `TWOC_M_CTC);
    assign fast    = (waveform_mode_select == `TWOC_M_FAST_FF) ||
                     (waveform_mode_select == `TWOC_M_FAST_CA);
    assign phase   = (waveform_mode_select == `TWOC_M_PC_FF) ||
                     (waveform_mode_select == `TWOC_M_PC_CA);

    always @* begin
        if (waveform_mode_select == `TWOC_M_CTC ||
            waveform_mode_select == `TWOC_M_PC_CA ||
            waveform_mode_select == `TWOC_M_FAST_CA)
            top = compare_value_a_r;
        else
            top = `TWOC_MAX;
    end

    assign at_top    = run && (count_r == top);
    assign at_bottom = run && (count_r == `TWOC_BOTTOM);

    // ==========================================================
    // APB access
    assign acc    = psel && penable;
    assign wr_cnt = acc && pwrite && (paddr == `TWOC_OFS_COUNT);

    always @* begin
        rdata_nxt = 32'h00000000;
        err_nxt   = 1'b0;
        if (paddr == `TWOC_OFS_CTRL_A)
            rdata_nxt[7:0] = timer_control_a_r & `TWOC_CTRL_A_MASK;
        else if (paddr == `TWOC_OFS_CTRL_B)
            rdata_nxt[3:0] = timer_control_b_r;
        else if (paddr == `TWOC_OFS_CMP_A)
            rdata_nxt[7:0] = cmp_a_buf_r;
        else if (paddr == `TWOC_OFS_CMP_B)
            rdata_nxt[7:0] = cmp_b_buf_r;
        else if (paddr == `TWOC_OFS_COUNT)
            rdata_nxt[7:0] = count_r;
        else if (paddr == `TWOC_OFS_STATUS)
            rdata_nxt[1:0] = {down_r, overflow_flag};
        else
            err_nxt = 1'b1;
    end

    // One wait state: ready in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && !pwrite) ? rdata_nxt : 32'h00000000;
            pslverr <= psel && penable && !pready && err_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_a_r <= `TWOC_RST_BYTE;
            timer_control_b_r <= 4'h0;
            cmp_a_buf_r       <= `TWOC_RST_BYTE;
            cmp_b_buf_r       <= `TWOC_RST_BYTE;
        end else if (acc && pwrite && pready) begin
            if (paddr == `TWOC_OFS_CTRL_A)
                timer_control_a_r <= pwdata[7:0] & `TWOC_CTRL_A_MASK;
            else if (paddr == `TWOC_OFS_CTRL_B)
                timer_control_b_r <= pwdata[3:0] & 4'h9;
            else if (paddr == `TWOC_OFS_CMP_A)
                cmp_a_buf_r <= pwdata[7:0];
            else if (paddr == `TWOC_OFS_CMP_B)
                cmp_b_buf_r <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Compare value reload
    always @* begin
        if (non_pwm || !run)
            load_now = 1'b1;
        else if (phase)
            load_now = at_top;
        else if (fast)
            load_now = at_bottom;
        else
            load_now = 1'b0;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_a_r <= `TWOC_RST_BYTE;
            compare_value_b_r <= `TWOC_RST_BYTE;
        end else if (load_now) begin
            compare_value_a_r <= cmp_a_buf_r;
            compare_value_b_r <= cmp_b_buf_r;
        end
    end

    // ==========================================================
    // Counter and overflow flag
    always @* begin
        count_nxt = count_r;
        down_nxt  = down_r;
        ovf_nxt   = overflow_flag;
        // Clear first, so a set in the same cycle wins
        if (acc && pwrite && pready && paddr == `TWOC_OFS_STATUS &&
            pwdata[0])
            ovf_nxt = 1'b0;
        if (wr_cnt && pready) begin
            count_nxt = pwdata[7:0];
        end else if (run) begin
            if (phase) begin
                if (!down_r && count_r == top) begin
                    down_nxt  = 1'b1;
                    count_nxt = count_r - 8'h01;
                end else if (down_r && count_r == `TWOC_BOTTOM) begin
                    down_nxt  = 1'b0;
                    count_nxt = 8'h01;
                end else if (down_r) begin
                    count_nxt = count_r - 8'h01;
                end else begin
                    count_nxt = count_r + 8'h01;
                end
                if (down_r && count_r == `TWOC_BOTTOM)
                    ovf_nxt = 1'b1;
            end else begin
                down_nxt  = 1'b0;
                count_nxt = (count_r == top) ? `TWOC_BOTTOM
                                             : count_r + 8'h01;
                // Flag at top in mode 7
                if (waveform_mode_select == `TWOC_M_FAST_CA)
                    ovf_nxt = ovf_nxt | (count_r == top);
                else
                    ovf_nxt = ovf_nxt | (count_r == `TWOC_MAX);
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r       <= `TWOC_BOTTOM;
            down_r        <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            count_r       <= count_nxt;
            down_r        <= down_nxt;
            overflow_flag <= ovf_nxt;
        end
    end

    // ==========================================================
    // Output channels
    twoc_out_chan #(.IS_A(1)) u_chan_a (
        .pclk        (pclk),
        .presetn     (presetn),
        .action      (timer_control_a_r[`TWOC_CA_ACT_HI:`TWOC_CA_ACT_LO]),
        .mode_hi     (timer_control_b_r[`TWOC_WGM_HIGH_BIT]),
        .non_pwm     (non_pwm),
        .fast        (fast),
        .phase       (phase),
        .match       (run && count_r == compare_value_a_r),
        .cmp_is_top  (compare_value_a_r == top),
        .at_bottom   (at_bottom),
        .at_top      (at_top),
        .counting_up (!down_r && !(count_r == top && phase)),
        .level_r     (compare_out_a_pin),
        .drive_r     (compare_out_a_override)
    );

    twoc_out_chan #(.IS_A(0)) u_chan_b (
        .pclk        (pclk),
        .presetn     (presetn),
        .action      (timer_control_a_r[`TWOC_CB_ACT_HI:`TWOC_CB_ACT_LO]),
        .mode_hi     (timer_control_b_r[`TWOC_WGM_HIGH_BIT]),
        .non_pwm     (non_pwm),
        .fast        (fast),
        .phase       (phase),
        .match       (run && count_r == compare_value_b_r),
        .cmp_is_top  (compare_value_b_r == top),
        .at_bottom   (at_bottom),
        .at_top      (at_top),
        .counting_up (!down_r && !(count_r == top && phase)),
        .level_r     (compare_out_b_pin),
        .drive_r     (compare_out_b_override)
    );

endmodule // twoc_timer

/* testbench/twoc_timer_properties.sv */
/* Checker for the timer block: APB answer timing, read-back masks,
   pin ownership and the sticky overflow flag.
   Assumes binding into twoc_timer, single clock pclk. */
`timescale 1ns/1ns
module twoc_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Timer outputs
    input wire logic        compare_out_a_override,
    input wire logic        compare_out_b_override,
    input wire logic        overflow_flag
);
    logic [7:0] sh_a_r;
    logic       sh_hi_r;
    logic [1:0] quiet_r;
    wire        acc  = psel && penable;
    wire        wr   = acc && pready && pwrite;
    wire        npwm = !sh_hi_r && !sh_a_r[0];
    wire        stl  = quiet_r == 2'h3;
    // =========================================
    // Shadow of control writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_a_r  <= 8'h00;
            sh_hi_r <= 1'b0;
            quiet_r <= 2'h0;
        end else if (wr && (paddr == 8'h00 || paddr == 8'h04)) begin
            if (paddr == 8'h00)
                sh_a_r <= pwdata[7:0];
            else
                sh_hi_r <= pwdata[3];
            quiet_r <= 2'h0;
        end else if (!stl) begin
            quiet_r <= quiet_r + 2'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =========================================
    // Properties
    property p_rdy_wait; pready |-> acc && $past(acc); endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("early ready");
    property p_rdy_one; acc && !$past(acc) |=> pready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready late");
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready long");
    property p_err_bad;
        pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0;
    endproperty
    a_err_bad: assert property (p_err_bad) else $error("no error");
    property p_err_ok;
        pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_err_ok: assert property (p_err_ok) else $error("false error");
    property p_rsv_zero;
        pready && !pwrite && paddr == 8'h00 |->
            prdata[3:2] == 2'h0 && prdata[31:8] == 24'h0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("bits 3:2");
    property p_ctl_b;
        pready && !pwrite && paddr == 8'h04 |-> prdata[31:4] == 28'h0;
    endproperty
    a_ctl_b: assert property (p_ctl_b) else $error("ctrl b");
    property p_ovr_off;
        stl && sh_a_r[7:6] == 2'h0 |-> !compare_out_a_override;
    endproperty
    a_ovr_off: assert property (p_ovr_off) else $error("a owned");
    property p_ovr_b;
        stl && npwm && sh_a_r[5:4] != 2'h0 |-> compare_out_b_override;
    endproperty
    a_ovr_b: assert property (p_ovr_b) else $error("b not owned");
    property p_b_rsv;
        stl && sh_a_r[0] && sh_a_r[5:4] == 2'h1 |-> !compare_out_b_override;
    endproperty
    a_b_rsv: assert property (p_b_rsv) else $error("b reserved");
    property p_a_tog;
        stl && sh_a_r[0] && sh_a_r[7:6] == 2'h1 |->
            compare_out_a_override == sh_hi_r;
    endproperty
    a_a_tog: assert property (p_a_tog) else $error("a toggle");
    property p_ovf_hold;
        overflow_flag && !(wr && paddr == 8'h14 && pwdata[0])
            |=> overflow_flag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("flag lost");
    c_err: cover property (pslverr);
    c_both: cover property (compare_out_a_override && compare_out_b_override);
    c_ovf: cover property ($rose(overflow_flag));
endmodule // twoc_chk

bind twoc_timer twoc_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_out_a_override(compare_out_a_override),
    .compare_out_b_override(compare_out_b_override),
    .overflow_flag(overflow_flag));

/* testbench/tb_top.sv */
/* Self-checking bench for twoc_timer: reset values, read-back,
   a table of mode rows measured at the pins, flag and reset cases.
   Assumes twoc_defs.vh on the include path; no far-side model. */
`timescale 1ns/1ns
`include "twoc_defs.vh"
module tb_top;
    typedef struct {logic [7:0] ca, cb, va, vb; int win, ha, hb;
                    logic oa, ob, f;} twoc_row_t;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, pa, oa, pb, ob, ovf;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    twoc_row_t   rows[11] = '{
        '{8'h52, 8'h01, 8'h09, 8'h03, 200, 100, 100, 1, 1, 0},
        '{8'hE2, 8'h01, 8'h09, 8'h03, 200, 200, 0, 1, 1, 0},
        '{8'hB3, 8'h01, 8'h40, 8'h40, 256, 64, 192, 1, 1, 1},
        '{8'h83, 8'h01, 8'hFF, 8'h00, 256, 256, -1, 1, 0, 1},
        '{8'hB1, 8'h01, 8'h40, 8'h40, 510, 128, 382, 1, 1, 1},
        '{8'h81, 8'h01, 8'hFF, 8'h00, 510, 510, -1, 1, 0, 1},
        '{8'h61, 8'h09, 8'h20, 8'h10, 256, 128, 128, 1, 1, 1},
        '{8'h63, 8'h09, 8'h1F, 8'h08, 256, 128, 64, 1, 1, 1},
        '{8'h51, 8'h01, 8'h40, 8'h40, 256, -1, -1, 0, 0, 1},
        '{8'hA0, 8'h09, 8'h40, 8'h40, 256, -1, -1, 1, 1, 1},
        '{8'hC0, 8'h01, 8'h10, 8'h00, 256, 256, -1, 1, 0, 1}};
    twoc_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compare_out_a_pin(pa), .compare_out_a_override(oa),
        .compare_out_b_pin(pb), .compare_out_b_override(ob),
        .overflow_flag(ovf));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(bit w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task run_row(twoc_row_t r);
        int na;
        int nb;
        apb(1, `TWOC_OFS_CTRL_B, 32'h0);
        apb(1, `TWOC_OFS_STATUS, 32'h1);
        apb(1, `TWOC_OFS_CMP_A, {24'h0, r.va});
        apb(1, `TWOC_OFS_CMP_B, {24'h0, r.vb});
        apb(1, `TWOC_OFS_CTRL_A, {24'h0, r.ca});
        apb(1, `TWOC_OFS_COUNT, 32'h0);
        apb(1, `TWOC_OFS_CTRL_B, {24'h0, r.cb});
        repeat (600) @(posedge pclk);
        na = 0;
        nb = 0;
        repeat (r.win) begin
            @(posedge pclk);
            na += (pa === 1'b1);
            nb += (pb === 1'b1);
        end
        chk("override a", {31'h0, r.oa}, {31'h0, oa});
        chk("override b", {31'h0, r.ob}, {31'h0, ob});
        chk("overflow", {31'h0, r.f}, {31'h0, ovf});
        if (r.ha >= 0)
            chk("high a", r.ha, na);
        if (r.hb >= 0)
            chk("high b", r.hb, nb);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 24; a += 4) begin
            apb(0, a[7:0], 32'h0);
            chk("reset read", 32'h0, rd);
        end
        chk("reset outs", 32'h0, {27'h0, ovf, oa, ob, pa, pb});
        $display("reset test done");
        apb(1, `TWOC_OFS_CTRL_A, 32'hFF);
        apb(0, `TWOC_OFS_CTRL_A, 32'h0);
        chk("ctrl a", 32'hF3, rd);
        apb(1, `TWOC_OFS_CTRL_B, 32'hFE);
        apb(0, `TWOC_OFS_CTRL_B, 32'h0);
        chk("ctrl b", 32'h08, rd);
        apb(1, `TWOC_OFS_CMP_A, 32'h1AB);
        apb(0, `TWOC_OFS_CMP_A, 32'h0);
        chk("cmp a", 32'hAB, rd);
        apb(1, 8'h18, 32'h1);
        chk("write refused", 32'h1, {31'h0, err});
        apb(0, 8'h18, 32'h0);
        chk("read refused", 32'h1, {31'h0, err});
        $display("register test done");
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        apb(1, `TWOC_OFS_CTRL_B, 32'h0);
        apb(1, `TWOC_OFS_STATUS, 32'h0);
        chk("flag kept", 32'h1, {31'h0, ovf});
        apb(1, `TWOC_OFS_STATUS, 32'h1);
        chk("flag cleared", 32'h0, {31'h0, ovf});
        $display("flag test done");
        apb(1, `TWOC_OFS_CTRL_B, 32'h1);
        repeat (300) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("mid reset outs", 32'h0, {29'h0, ovf, oa, pa});
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `TWOC_OFS_CTRL_A, 32'h0);
        chk("mid reset ctrl a", 32'h0, rd);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule // tb_top
